// File: hw/tweep_pkg.sv
// constants, command codes and helpers shared by the serial eeprom command port
package tweep_pkg;

	// framing on the serial input
	localparam logic [1:0] OP_READ      = 2'h2;
	localparam logic [1:0] OP_WRITE     = 2'h1;
	localparam logic [1:0] OP_ERASE     = 2'h3;
	localparam logic [1:0] OP_SPECIAL   = 2'h0;
	localparam logic [1:0] FN_UNLOCK    = 2'h3;
	localparam logic [1:0] FN_ERASE_ALL = 2'h2;
	localparam logic [1:0] FN_FILL      = 2'h1;
	localparam logic [1:0] FN_LOCK      = 2'h0;

	// field lengths per organisation
	localparam logic [4:0] ADDR_BITS_X8  = 5'h07;
	localparam logic [4:0] ADDR_BITS_X16 = 5'h06;
	localparam logic [4:0] DATA_BITS_X8  = 5'h08;
	localparam logic [4:0] DATA_BITS_X16 = 5'h10;

	// array geometry and contents
	localparam int          MEM_WORDS   = 64;
	localparam int          MEM_WIDTH   = 16;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [15:0] RESET_WORD  = 16'h0000;

	// timing
	localparam int CORE_CLK_HZ       = 20000000;
	localparam int MIN_SELECT_LOW_NS = 250;
	localparam int PROG_TIME_US      = 5000;
	localparam int PROG_CYCLES       = PROG_TIME_US * (CORE_CLK_HZ / 1000000);

	// the seven instructions
	typedef enum logic [2:0] {
		CMD_READ      = 3'h0,
		CMD_WRITE     = 3'h1,
		CMD_ERASE     = 3'h2,
		CMD_UNLOCK    = 3'h3,
		CMD_LOCK      = 3'h4,
		CMD_ERASE_ALL = 3'h5,
		CMD_FILL      = 3'h6
	} tweep_cmd_t;

	function automatic logic [4:0] addr_len(input logic wide);
		addr_len = wide ? ADDR_BITS_X16 : ADDR_BITS_X8;
	endfunction

	function automatic logic [4:0] data_len(input logic wide);
		data_len = wide ? DATA_BITS_X16 : DATA_BITS_X8;
	endfunction

endpackage

// File: hw/tweep_mem.sv
// eeprom array: one port, byte write enables, registered read data
`timescale 1ns/1ps
module tweep_mem #(
	parameter int WORDS = 64,
	parameter int WIDTH = 16,
	parameter int AW    = 6
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             we,
	input  wire logic [1:0]       be,
	input  wire logic [AW-1:0]    addr,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] rdata_r
);
	logic [WIDTH-1:0] mem [WORDS];

	initial begin
		if (WIDTH != 16 || WORDS > (1 << AW))
			$error("tweep_mem: unsupported geometry");
	end

	// byte-lane writes
	always_ff @(posedge clk) begin
		if (we && be[0])
			mem[addr][7:0] <= wdata[7:0];
		if (we && be[1])
			mem[addr][15:8] <= wdata[15:8];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdata_r <= '0;
		else
			rdata_r <= mem[addr];
	end
endmodule // tweep_mem

// File: hw/tweep_cmd_port.sv
// three-wire serial eeprom command port: link shifter, command crossing, self-timed programming
`timescale 1ns/1ps
module tweep_cmd_port
#(
	parameter int PROG_CYCLES_P = tweep_pkg::PROG_CYCLES
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic serial_clock,
	input  wire logic chip_select,
	input  wire logic serial_in,
	input  wire logic width_select,
	output logic      serial_out,
	output logic      serial_out_oe
);
	import tweep_pkg::*;

	initial begin
		if (PROG_CYCLES_P < MEM_WORDS || PROG_CYCLES_P >= (1 << 20))
			$error("tweep_cmd_port: PROG_CYCLES_P out of range");
	end

	typedef enum logic [2:0] {
		LK_WAIT = 3'h0,
		LK_OPC  = 3'h1,
		LK_ADDR = 3'h3,
		LK_DATA = 3'h2,
		LK_READ = 3'h6,
		LK_DONE = 3'h7
	} tweep_link_t;

	typedef enum logic [1:0] {
		CS_IDLE = 2'h0,
		CS_RD   = 2'h1,
		CS_BUSY = 2'h2
	} tweep_core_t;

	// link domain (serial_clock); framing cleared whenever select is low, organisation synchroniser only by rst
	logic        link_rst;
	tweep_link_t phase_r;
	logic [4:0]  pos_r;
	logic [15:0] sh_r;
	logic [1:0]  op_r;
	logic [15:0] out_sh_r;
	logic [4:0]  rcnt_r;
	logic        do_r;
	logic        do_oe_r;
	logic        lk_org_s1;
	logic        lk_org_s2;
	logic [4:0]  alen;
	logic [4:0]  dlen;
	logic [6:0]  addr_w;
	logic [15:0] data_w;
	logic [1:0]  fn_w;
	logic        addr_last;
	logic        data_last;
	logic        issue;
	tweep_cmd_t  issue_code;

	// payload handed to the core, reset only by rst
	logic        cmd_tgl_r;
	tweep_cmd_t  cmd_code_r;
	logic [6:0]  cmd_addr_r;
	logic [15:0] cmd_data_r;

	// core domain
	logic        cs_s1, cs_s2, cs_s3;
	logic        tgl_s1, tgl_s2, tgl_s3;
	logic        org_s1, org_s2;
	logic        cmd_ev;
	logic        cs_rise;
	tweep_core_t state_r;
	logic [19:0] tmr_r;
	tweep_cmd_t  cur_code_r;
	logic [6:0]  cur_addr_r;
	logic [15:0] cur_data_r;
	logic        prog_en_r;
	logic        armed_r;
	logic        status_r;
	logic        ready_r;
	logic [15:0] rd_word_r;
	logic        prog_ok;
	logic        busy_end;
	logic        mem_we;
	logic [1:0]  mem_be;
	logic [5:0]  mem_addr;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;
	logic        single_op;

	function automatic logic [5:0] word_of(input logic wide, input logic [6:0] a);
		word_of = wide ? a[5:0] : a[6:1];
	endfunction

	function automatic logic is_prog(input tweep_cmd_t c);
		is_prog = (c == CMD_WRITE) || (c == CMD_ERASE) || (c == CMD_ERASE_ALL) || (c == CMD_FILL);
	endfunction

	assign link_rst = rst | ~chip_select;

	always_ff @(posedge serial_clock or posedge rst) begin
		if (rst) begin
			lk_org_s1 <= 1'b0;
			lk_org_s2 <= 1'b0;
		end else begin
			lk_org_s1 <= width_select;
			lk_org_s2 <= lk_org_s1;
		end
	end

	// field lengths and assembled fields, msb first
	always_comb begin
		alen = addr_len(lk_org_s2);
		dlen = data_len(lk_org_s2);
		addr_w = lk_org_s2 ? {1'b0, sh_r[4:0], serial_in} : {sh_r[5:0], serial_in};
		data_w = lk_org_s2 ? {sh_r[14:0], serial_in} : {8'h00, sh_r[6:0], serial_in};
		fn_w = lk_org_s2 ? addr_w[5:4] : addr_w[6:5];
		addr_last = (phase_r == LK_ADDR) && (pos_r == alen - 5'h01);
		data_last = (phase_r == LK_DATA) && (pos_r == dlen - 5'h01);
	end

	// instruction decode at the end of address or data
	always_comb begin
		issue      = 1'b0;
		issue_code = CMD_READ;
		if (data_last) begin
			issue      = 1'b1;
			issue_code = (op_r == OP_WRITE) ? CMD_WRITE : CMD_FILL;
		end else if (addr_last && op_r == OP_READ) begin
			issue      = 1'b1;
			issue_code = CMD_READ;
		end else if (addr_last && op_r == OP_ERASE) begin
			issue      = 1'b1;
			issue_code = CMD_ERASE;
		end else if (addr_last && op_r == OP_SPECIAL && fn_w != FN_FILL) begin
			issue      = 1'b1;
			issue_code = (fn_w == FN_UNLOCK) ? CMD_UNLOCK : ((fn_w == FN_LOCK) ? CMD_LOCK : CMD_ERASE_ALL);
		end
	end

	// serial framing: start bit, opcode, address, data, read-out
	always_ff @(posedge serial_clock or posedge link_rst) begin
		if (link_rst) begin
			phase_r  <= LK_WAIT;
			pos_r    <= '0;
			sh_r     <= '0;
			op_r     <= OP_SPECIAL;
			out_sh_r <= '0;
			rcnt_r   <= '0;
			do_r     <= 1'b0;
			do_oe_r  <= 1'b0;
		end else begin
			if (phase_r == LK_OPC || phase_r == LK_ADDR || phase_r == LK_DATA)
				sh_r <= {sh_r[14:0], serial_in};
			case (phase_r)
				LK_WAIT: begin
					if (serial_in)
						phase_r <= LK_OPC;
				end
				LK_OPC: begin
					pos_r <= pos_r + 5'h01;
					if (pos_r == 5'h01) begin
						op_r    <= {sh_r[0], serial_in};
						pos_r   <= '0;
						phase_r <= LK_ADDR;
					end
				end
				LK_ADDR: begin
					pos_r <= pos_r + 5'h01;
					if (addr_last) begin
						pos_r <= '0;
						if (op_r == OP_READ) begin
							phase_r <= LK_READ;
							do_r    <= 1'b0;
							do_oe_r <= 1'b1;
						end else if (op_r == OP_WRITE || (op_r == OP_SPECIAL && fn_w == FN_FILL))
							phase_r <= LK_DATA;
						else
							phase_r <= LK_DONE;
					end
				end
				LK_DATA: begin
					pos_r <= pos_r + 5'h01;
					if (data_last)
						phase_r <= LK_DONE;
				end
				LK_READ: begin
					if (rcnt_r == 5'h00) begin
						out_sh_r <= {rd_word_r[14:0], 1'b0};
						do_r     <= rd_word_r[15];
						rcnt_r   <= 5'h01;
					end else if (rcnt_r < dlen) begin
						out_sh_r <= {out_sh_r[14:0], 1'b0};
						do_r     <= out_sh_r[15];
						rcnt_r   <= rcnt_r + 5'h01;
					end else
						do_r <= 1'b0;
				end
				default: phase_r <= LK_DONE;
			endcase
		end
	end

	// command handover: payload registered on or before the edge of the toggle that marks it (address at the end of the address field)
	always_ff @(posedge serial_clock or posedge rst) begin
		if (rst) begin
			cmd_tgl_r  <= 1'b0;
			cmd_code_r <= CMD_READ;
			cmd_addr_r <= '0;
			cmd_data_r <= '0;
		end else begin
			if (addr_last)
				cmd_addr_r <= addr_w;
			if (data_last)
				cmd_data_r <= data_w;
			if (issue) begin
				cmd_code_r <= issue_code;
				cmd_tgl_r  <= ~cmd_tgl_r;
			end
		end
	end

	// synchronisers into the core clock
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cs_s1  <= 1'b0;
			cs_s2  <= 1'b0;
			cs_s3  <= 1'b0;
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
			tgl_s3 <= 1'b0;
			org_s1 <= 1'b0;
			org_s2 <= 1'b0;
		end else begin
			cs_s1  <= chip_select;
			cs_s2  <= cs_s1;
			cs_s3  <= cs_s2;
			tgl_s1 <= cmd_tgl_r;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
			org_s1 <= width_select;
			org_s2 <= org_s1;
		end
	end

	assign cmd_ev   = tgl_s2 ^ tgl_s3;
	assign cs_rise  = cs_s2 & ~cs_s3;
	assign prog_ok  = cmd_ev && (state_r == CS_IDLE) && is_prog(cmd_code_r) && prog_en_r;
	assign busy_end = (state_r == CS_BUSY) && (tmr_r == 20'(PROG_CYCLES_P - 1));

	// programming latch
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			prog_en_r <= 1'b0;
		else if (cmd_ev && state_r == CS_IDLE && cmd_code_r == CMD_UNLOCK)
			prog_en_r <= 1'b1;
		else if (cmd_ev && state_r == CS_IDLE && cmd_code_r == CMD_LOCK)
			prog_en_r <= 1'b0;
	end

	// core sequencer: read fetch and self-timed cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r    <= CS_IDLE;
			tmr_r      <= '0;
			cur_code_r <= CMD_READ;
			cur_addr_r <= '0;
			cur_data_r <= '0;
		end else begin
			case (state_r)
				CS_IDLE: begin
					tmr_r <= '0;
					if (cmd_ev && cmd_code_r == CMD_READ)
						state_r <= CS_RD;
					else if (prog_ok) begin
						state_r    <= CS_BUSY;
						cur_code_r <= cmd_code_r;
						cur_addr_r <= cmd_addr_r;
						cur_data_r <= cmd_data_r;
					end
				end
				CS_RD: state_r <= CS_IDLE;
				CS_BUSY: begin
					tmr_r <= tmr_r + 20'h00001;
					if (busy_end)
						state_r <= CS_IDLE;
				end
				default: state_r <= CS_IDLE;
			endcase
		end
	end

	// array access: one word for single ops, a sweep for the whole-array ops
	always_comb begin
		single_op = (cur_code_r == CMD_WRITE) || (cur_code_r == CMD_ERASE);
		mem_we    = 1'b0;
		mem_be    = 2'h3;
		mem_addr  = word_of(org_s2, cmd_addr_r);
		mem_wdata = ERASED_WORD;
		if (state_r == CS_BUSY) begin
			mem_addr = single_op ? word_of(org_s2, cur_addr_r) : tmr_r[5:0];
			mem_we   = single_op ? (tmr_r == 20'h00000) : (tmr_r < 20'(MEM_WORDS));
			if (single_op && !org_s2)
				mem_be = cur_addr_r[0] ? 2'h2 : 2'h1;
			if (cur_code_r == CMD_WRITE || cur_code_r == CMD_FILL)
				mem_wdata = org_s2 ? cur_data_r : {cur_data_r[7:0], cur_data_r[7:0]};
			else
				mem_wdata = ERASED_WORD;
		end
	end

	tweep_mem #(
		.WORDS(MEM_WORDS),
		.WIDTH(MEM_WIDTH),
		.AW   (6)
	) u_mem (
		.clk    (core_clk),
		.rst    (rst),
		.we     (mem_we),
		.be     (mem_be),
		.addr   (mem_addr),
		.wdata  (mem_wdata),
		.rdata_r(mem_rdata)
	);

	// read word, left aligned for the shifter
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			rd_word_r <= RESET_WORD;
		else if (state_r == CS_RD)
			rd_word_r <= org_s2 ? mem_rdata : (cmd_addr_r[0] ? {mem_rdata[15:8], 8'h00} : {mem_rdata[7:0], 8'h00});
	end

	// ready/busy presentation
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			armed_r  <= 1'b0;
			status_r <= 1'b0;
			ready_r  <= 1'b1;
		end else begin
			ready_r <= (state_r != CS_BUSY) && !prog_ok;
			if (prog_ok)
				armed_r <= 1'b1;
			else if (cs_rise || (state_r != CS_BUSY && !cs_s2))
				armed_r <= 1'b0;
			if (cs_rise && armed_r)
				status_r <= 1'b1;
			else if (!cs_s2)
				status_r <= 1'b0;
		end
	end

	assign serial_out    = status_r ? ready_r : do_r;
	assign serial_out_oe = status_r | do_oe_r;

	chk_latch_reset: assert property (@(posedge core_clk) $fell(rst) |-> !prog_en_r)
		else $error("latch not disabled after reset");
	chk_locked_ignore: assert property (@(posedge core_clk) disable iff (rst)
		(cmd_ev && state_r == CS_IDLE && is_prog(cmd_code_r) && !prog_en_r) |=> state_r == CS_IDLE)
		else $error("programming ran while locked");
	chk_latch_holds: assert property (@(posedge core_clk) disable iff (rst)
		(prog_en_r && !(cmd_ev && cmd_code_r == CMD_LOCK)) |=> prog_en_r)
		else $error("latch dropped without lock");
	chk_lock_clears: assert property (@(posedge core_clk) disable iff (rst)
		(cmd_ev && state_r == CS_IDLE && cmd_code_r == CMD_LOCK) |=> !prog_en_r ##1 state_r != CS_BUSY)
		else $error("lock did not clear latch");
	chk_busy_length: assert property (@(posedge core_clk) disable iff (rst)
		$rose(state_r == CS_BUSY) |-> (state_r == CS_BUSY && tmr_r == 20'h00000) ##1 (state_r == CS_BUSY)[*8])
		else $error("self-timed cycle too short");
	chk_busy_status: assert property (@(posedge core_clk) disable iff (rst)
		(status_r && $past(state_r) == CS_BUSY && state_r == CS_BUSY) |-> serial_out_oe && !serial_out)
		else $error("status not busy during cycle");
	chk_late_status: assert property (@(posedge core_clk) disable iff (rst)
		$rose(status_r) |-> $past(armed_r) && $past(cs_rise))
		else $error("status shown without armed cycle");
	chk_erase_ones: assert property (@(posedge core_clk) disable iff (rst)
		(state_r == CS_BUSY && tmr_r == 20'h00000 && cur_code_r == CMD_ERASE) |-> mem_we && mem_wdata == ERASED_WORD)
		else $error("erase did not write ones");
	chk_read_free: assert property (@(posedge core_clk) disable iff (rst)
		(cmd_ev && state_r == CS_IDLE && cmd_code_r == CMD_READ) |=> state_r == CS_RD ##1 state_r == CS_IDLE)
		else $error("read not served");
	chk_select_float: assert property (@(posedge core_clk) disable iff (rst)
		(!cs_s2 && !chip_select) |=> !serial_out_oe)
		else $error("output driven while deselected");
	chk_dummy_zero: assert property (@(posedge serial_clock) disable iff (link_rst)
		$rose(phase_r == LK_READ) |-> do_oe_r && !do_r ##1 rcnt_r == 5'h01)
		else $error("dummy bit not zero");
endmodule // tweep_cmd_port

// File: verif/tweep_host.sv
// host-side model that drives the three-wire link
`timescale 1ns/1ps
module tweep_host (
	output logic serial_clock,
	output logic chip_select,
	output logic serial_in
);
	initial begin
		serial_clock = 1'b0;
		chip_select  = 1'b0;
		serial_in    = 1'b0;
	end
	// one 12 ns link clock, data set half a period before the rise
	task automatic tick(input logic b);
		serial_in = b;
		#6 serial_clock = 1'b1;
		#6 serial_clock = 1'b0;
	endtask
	// select high, start bit, then n bits msb first; select stays high
	task automatic send(input logic [31:0] bits, input int n);
		chip_select = 1'b1;
		#20;
		tick(1'b1);
		for (int i = n - 1; i >= 0; i--) begin
			tick(bits[i]);
		end
		serial_in = ~serial_in;
	endtask
	// select low for longer than the minimum low time
	task automatic drop();
		#20 chip_select = 1'b0;
		#300;
	endtask
	task automatic raise();
		chip_select = 1'b1;
	endtask
endmodule // tweep_host

// File: verif/tweep_cmd_port_test.sv
// self-checking bench for the serial eeprom command port
`timescale 1ns/1ps
module tweep_cmd_port_test;
	import tweep_pkg::*;
	localparam int PROG = 100;
	typedef struct packed {
		logic [1:0]  op;
		logic [6:0]  addr;
		logic [15:0] data;
		logic        has_data;
		logic        rd;
		logic        st;
	} tweep_row_t;
	logic core_clk;
	logic rst;
	logic width_select;
	logic serial_clock;
	logic chip_select;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe;
	wire  do_line = serial_out_oe ? serial_out : 1'bz;
	int   mismatches;
	int   checks_done;
	tweep_row_t rows [15] = '{
		'{OP_WRITE,   7'h03, 16'hA5A5, 1'b1, 1'b0, 1'b0},
		'{OP_SPECIAL, 7'h30, 16'h0000, 1'b0, 1'b0, 1'b0},
		'{OP_WRITE,   7'h05, 16'h1234, 1'b1, 1'b0, 1'b1},
		'{OP_READ,    7'h05, 16'h1234, 1'b0, 1'b1, 1'b0},
		'{OP_ERASE,   7'h05, 16'h0000, 1'b0, 1'b0, 1'b1},
		'{OP_READ,    7'h05, 16'hFFFF, 1'b0, 1'b1, 1'b0},
		'{OP_SPECIAL, 7'h10, 16'h5AC3, 1'b1, 1'b0, 1'b1},
		'{OP_READ,    7'h3F, 16'h5AC3, 1'b0, 1'b1, 1'b0},
		'{OP_SPECIAL, 7'h20, 16'h0000, 1'b0, 1'b0, 1'b1},
		'{OP_READ,    7'h00, 16'hFFFF, 1'b0, 1'b1, 1'b0},
		'{OP_WRITE,   7'h3E, 16'h0F0F, 1'b1, 1'b0, 1'b1},
		'{OP_SPECIAL, 7'h00, 16'h0000, 1'b0, 1'b0, 1'b0},
		'{OP_WRITE,   7'h3E, 16'h0000, 1'b1, 1'b0, 1'b0},
		'{OP_READ,    7'h3E, 16'h0F0F, 1'b0, 1'b1, 1'b0},
		'{OP_READ,    7'h03, 16'hFFFF, 1'b0, 1'b1, 1'b0}
	};

	tweep_cmd_port #(.PROG_CYCLES_P(PROG)) i_tweep_cmd_port (
		.core_clk      (core_clk),
		.rst           (rst),
		.serial_clock  (serial_clock),
		.chip_select   (chip_select),
		.serial_in     (serial_in),
		.width_select  (width_select),
		.serial_out    (serial_out),
		.serial_out_oe (serial_out_oe)
	);
	tweep_host i_tweep_host (
		.serial_clock (serial_clock),
		.chip_select  (chip_select),
		.serial_in    (serial_in)
	);

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic check(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// one full instruction, read-back and status phase
	task automatic run(input tweep_row_t r, input logic late);
		logic [4:0]  al;
		logic [4:0]  dl;
		logic [31:0] bits;
		logic [15:0] got;
		int          cnt;
		al = width_select ? ADDR_BITS_X16 : ADDR_BITS_X8;
		dl = width_select ? DATA_BITS_X16 : DATA_BITS_X8;
		bits = (32'(r.op) << al) | 32'(r.addr);
		if (r.has_data) begin
			bits = (bits << dl) | 32'(r.data);
		end
		i_tweep_host.send(bits, 2 + int'(al) + (r.has_data ? int'(dl) : 0));
		if (r.rd) begin
			#400;
			check(do_line === 1'b0, "dummy bit");
			got = '0;
			for (int i = 0; i < int'(dl); i++) begin
				i_tweep_host.tick(~serial_in);
				got = {got[14:0], do_line};
			end
			check(got === r.data, "read data");
		end
		i_tweep_host.drop();
		if (late) begin
			repeat (PROG + 20) @(posedge core_clk);
		end
		i_tweep_host.raise();
		repeat (4) @(posedge core_clk);
		#1;
		check(serial_out_oe === (r.st && !late), "status enable");
		if (r.st && !late) begin
			check(do_line === 1'b0, "busy level");
			cnt = 0;
			while (do_line !== 1'b1 && cnt < PROG + 20) begin
				@(posedge core_clk);
				#1;
				cnt++;
			end
			check(cnt > PROG - 20 && cnt < PROG - 1, "busy length");
		end
		i_tweep_host.drop();
	endtask

	initial begin
		#1ms;
		mismatches++;
		$display("[FAIL] %0t watchdog", $time);
		stop_test();
	end

	initial begin
		rst = 1'b1;
		width_select = 1'b1;
		repeat (10) @(posedge core_clk);
		check(serial_out_oe === 1'b0, "reset float");
		rst <= 1'b0;
		repeat (2) i_tweep_host.tick(1'b0);
		repeat (3) @(posedge core_clk);
		foreach (rows[k]) begin
			run(rows[k], 1'b0);
			$display("row %0d done", k);
		end
		// aborted read: select low floats the output
		i_tweep_host.send(32'h00000085, 8);
		#400;
		repeat (3) i_tweep_host.tick(1'b0);
		i_tweep_host.drop();
		check(serial_out_oe === 1'b0, "abort float");
		$display("abort test done");
		// byte organisation after a reset
		@(posedge core_clk);
		rst <= 1'b1;
		width_select <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) i_tweep_host.tick(1'b0);
		repeat (3) @(posedge core_clk);
		run('{OP_WRITE, 7'h0B, 16'h003C, 1'b1, 1'b0, 1'b0}, 1'b0);
		run('{OP_READ, 7'h0B, 16'h00FF, 1'b0, 1'b1, 1'b0}, 1'b0);
		run('{OP_SPECIAL, 7'h60, 16'h0000, 1'b0, 1'b0, 1'b0}, 1'b0);
		run('{OP_WRITE, 7'h0B, 16'h003C, 1'b1, 1'b0, 1'b1}, 1'b0);
		run('{OP_READ, 7'h0B, 16'h003C, 1'b0, 1'b1, 1'b0}, 1'b0);
		run('{OP_WRITE, 7'h0B, 16'h00C3, 1'b1, 1'b0, 1'b1}, 1'b1);
		run('{OP_READ, 7'h0B, 16'h00C3, 1'b0, 1'b1, 1'b0}, 1'b0);
		$display("byte test done");
		stop_test();
	end
endmodule // tweep_cmd_port_test
